// file: design/byte_ecc_correct.sv
/*
 Single-bit corrector for one EEPROM byte with a four-bit Hamming check code.
 Assumes the code was written with the matching encoder on the write path.
*/
module byte_ecc_correct (
  input  wire logic [7:0] data_in,      // Raw byte
  input  wire logic [3:0] check_in,     // Stored check bits
  output logic      [7:0] data_out,     // Corrected byte
  output logic            corrected_out // A bit was flipped back
);
  logic [3:0] syn;
  logic [7:0] flip;

  assign syn[0] = check_in[0] ^ data_in[0] ^ data_in[1] ^ data_in[3] ^ data_in[4] ^ data_in[6];
  assign syn[1] = check_in[1] ^ data_in[0] ^ data_in[2] ^ data_in[3] ^ data_in[5] ^ data_in[6];
  assign syn[2] = check_in[2] ^ data_in[1] ^ data_in[2] ^ data_in[3] ^ data_in[7];
  assign syn[3] = check_in[3] ^ data_in[4] ^ data_in[5] ^ data_in[6] ^ data_in[7];

  // Syndrome gives the Hamming position; data bits sit at 3,5,6,7,9,10,11,12
  assign flip[0] = (syn == 4'h3);
  assign flip[1] = (syn == 4'h5);
  assign flip[2] = (syn == 4'h6);
  assign flip[3] = (syn == 4'h7);
  assign flip[4] = (syn == 4'h9);
  assign flip[5] = (syn == 4'ha);
  assign flip[6] = (syn == 4'hb);
  assign flip[7] = (syn == 4'hc);

  assign data_out      = data_in ^ flip;
  assign corrected_out = |flip;
endmodule : byte_ecc_correct

// file: design/fault_pkg.sv
/*
 Constants shared by the fault response monitor and its helpers.
 Assumes a single 100 MHz system clock and a synchronous active-low reset.
*/
package fault_pkg;
  // ==========================================================
  // Register map
  localparam logic [3:0] ADDR_RESET_CAUSE  = 4'h0;
  localparam logic [3:0] ADDR_EXC_STATUS   = 4'h1;
  localparam logic [3:0] ADDR_EXC_CLEAR    = 4'h2;
  localparam logic [3:0] ADDR_EXC_ENABLE   = 4'h3;
  localparam logic [3:0] ADDR_LIGHT_SEL    = 4'h4;
  localparam logic [3:0] ADDR_HV_STATUS    = 4'h5;
  localparam logic [3:0] ADDR_SP_LIMIT_LO  = 4'h6;
  localparam logic [3:0] ADDR_SP_LIMIT_HI  = 4'h7;
  localparam logic [3:0] ADDR_SENSOR_CTRL  = 4'h8;
  // ==========================================================
  // Exception reason bits
  localparam int EXC_BITS       = 9;
  localparam int EXC_LIGHT      = 0;
  localparam int EXC_PC         = 1;
  localparam int EXC_SP         = 2;
  localparam int EXC_PSW        = 3;
  localparam int EXC_DES        = 4;
  localparam int EXC_MODARITH   = 5;
  localparam int EXC_STK_USER   = 6;
  localparam int EXC_STK_SYS    = 7;
  localparam int EXC_STK_SUPER  = 8;
  // ==========================================================
  // Reset cause bits
  localparam int CAUSE_BITS     = 7;
  localparam int CAUSE_VOLT     = 0;
  localparam int CAUSE_FREQ     = 1;
  localparam int CAUSE_TEMP     = 2;
  localparam int CAUSE_LIGHT    = 3;
  localparam int CAUSE_ROM_PAR  = 4;
  localparam int CAUSE_POWERON  = 5;
  localparam int CAUSE_OTHER    = 6;
  // ==========================================================
  // Reset values and modes
  localparam logic [1:0]  LIGHT_SEL_RESET = 2'h0;
  localparam logic [1:0]  LIGHT_OFF       = 2'h0;
  localparam logic [1:0]  LIGHT_FUNC_A    = 2'h1;
  localparam logic [1:0]  LIGHT_FUNC_B    = 2'h2;
  localparam logic [15:0] SP_LIMIT_RESET  = 16'h0000;
  localparam int          MODE_USER       = 0;
  localparam int          MODE_SYS        = 1;
  localparam int          MODE_SUPER      = 2;
  localparam int          PSW_PRIV_BIT    = 7;
  localparam logic [3:0]  RESET_PULSE_CYC = 4'h4;
endpackage : fault_pkg

// file: design/fault_response_monitor.sv
/*
 Fault response monitor: turns sensor, fault, stack, memory and EEPROM
 light events into a forced chip reset or a processor exception.
 Assumes all inputs are synchronous to mclk_in and that the chip reset
 generator holds rst_n_in low while reset_req_out is high.
*/
module fault_response_monitor
  import fault_pkg::*;
#(
  parameter int SP_W = 16
) (
  input  wire logic            mclk_in,          // System clock, 100 MHz
  input  wire logic            rst_n_in,         // Synchronous reset, active low
  input  wire logic            test_mode_in,     // Factory test mode active
  input  wire logic            poweron_in,       // Power-on reset was the source
  input  wire logic            volt_alarm_in,    // Supply out of range
  input  wire logic            freq_alarm_in,    // Clock frequency out of range
  input  wire logic            temp_alarm_in,    // Temperature out of range
  input  wire logic            light_alarm_in,   // Surface light sensor tripped
  input  wire logic            ee_light_a_in,    // EEPROM light detector A
  input  wire logic            ee_light_b_in,    // EEPROM light detector B
  input  wire logic            fault_pc_in,      // Program counter fault
  input  wire logic            fault_sp_in,      // Stack pointer fault
  input  wire logic            fault_psw_in,     // Status register fault
  input  wire logic            fault_des_in,     // Cipher coprocessor fault
  input  wire logic            fault_modarith_in,// Modular arithmetic fault
  input  wire logic [7:0]      processor_status_high_in, // High status register
  input  wire logic            user_mode_in,     // Processor in user mode
  input  wire logic [SP_W-1:0] sp_user_in,       // User stack pointer
  input  wire logic [SP_W-1:0] sp_sys_in,        // System stack pointer
  input  wire logic [SP_W-1:0] sp_super_in,      // Privileged stack pointer
  input  wire logic            rom_rd_in,        // ROM read strobe
  input  wire logic [7:0]      rom_data_in,      // ROM byte
  input  wire logic            rom_parity_in,    // Stored odd parity bit
  input  wire logic [7:0]      ee_data_in,       // Raw EEPROM byte
  input  wire logic [3:0]      ee_check_in,      // EEPROM check bits
  input  wire logic            ee_write_in,      // EEPROM write sequence active
  input  wire logic            hv_ok_in,         // Programming voltage good
  input  wire logic [3:0]      addr_in,          // Register address
  input  wire logic [15:0]     wdata_in,         // Register write data
  input  wire logic            wr_in,            // Write strobe
  input  wire logic            rd_in,            // Read strobe
  output logic      [15:0]     rdata_out,        // Read data, cycle after strobe
  output logic      [7:0]      ee_data_out,      // Corrected EEPROM byte
  output logic                 ee_corrected_out, // Correction applied
  output logic                 sensors_en_out,   // Enable to all sensors
  output logic                 reset_req_out,    // Force chip reset
  output logic                 exception_out,    // Exception request pulse
  output logic                 irq_out           // Level interrupt
);
  if (SP_W < 2 || SP_W > 16) begin : g_bad_sp_w
    $error("SP_W must be 2 to 16");
  end

  // ==========================================================
  // Registers
  logic [CAUSE_BITS-1:0] cause_r;
  logic [CAUSE_BITS-1:0] cause_nxt;
  logic                  cause_caught_r;
  logic [EXC_BITS-1:0]   exc_stat_r;
  logic [EXC_BITS-1:0]   exc_stat_nxt;
  logic [EXC_BITS-1:0]   exc_en_r;
  logic [1:0]            light_sel_r;
  logic                  hv_fail_r;
  logic                  hv_done_r;
  logic [SP_W-1:0]       lim_lo_r [3];
  logic [SP_W-1:0]       lim_hi_r [3];
  logic [1:0]            lim_sel_r;
  logic [3:0]            rst_cnt_r;
  logic                  exc_r;
  logic [15:0]           rdata_r;

  // Pending reset cause survives the chip reset it provokes
  logic [CAUSE_BITS-1:0] pend_cause_r;

  // ==========================================================
  // Event sources
  logic                  rom_par_err;
  logic                  ee_light;
  logic [CAUSE_BITS-1:0] rst_ev;
  logic [EXC_BITS-1:0]   exc_ev;
  logic                  any_rst;
  logic                  any_exc;
  logic [2:0]            mode_act;
  logic [2:0]            stk_hit;
  logic [SP_W-1:0]       sp_sel [3];
  logic                  priv;

  assign sensors_en_out = !test_mode_in;
  assign rom_par_err    = rom_rd_in && !(^{rom_data_in, rom_parity_in});

  assign ee_light = (light_sel_r == LIGHT_FUNC_A) ? ee_light_a_in :
                    (light_sel_r == LIGHT_FUNC_B) ? ee_light_b_in : 1'b0;

  // Hard-wired mapping: no register reaches these assignments
  assign rst_ev[CAUSE_VOLT]    = sensors_en_out && volt_alarm_in;
  assign rst_ev[CAUSE_FREQ]    = sensors_en_out && freq_alarm_in;
  assign rst_ev[CAUSE_TEMP]    = sensors_en_out && temp_alarm_in;
  assign rst_ev[CAUSE_LIGHT]   = sensors_en_out && light_alarm_in;
  assign rst_ev[CAUSE_ROM_PAR] = rom_par_err;
  assign rst_ev[CAUSE_POWERON] = 1'b0;
  assign rst_ev[CAUSE_OTHER]   = 1'b0;
  assign any_rst = |rst_ev;

  assign priv        = processor_status_high_in[PSW_PRIV_BIT];
  assign mode_act[MODE_SUPER] = priv;
  assign mode_act[MODE_USER]  = !priv && user_mode_in;
  assign mode_act[MODE_SYS]   = !priv && !user_mode_in;
  assign sp_sel[MODE_USER]  = sp_user_in;
  assign sp_sel[MODE_SYS]   = sp_sys_in;
  assign sp_sel[MODE_SUPER] = sp_super_in;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_stack
      stack_limit_check #(
        .SP_W(SP_W)
      ) u_chk (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .active_in(mode_act[g]),
        .sp_in    (sp_sel[g]),
        .lo_in    (lim_lo_r[g]),
        .hi_in    (lim_hi_r[g]),
        .hit_out  (stk_hit[g])
      );
    end
  endgenerate

  assign exc_ev[EXC_LIGHT]     = sensors_en_out && ee_light;
  assign exc_ev[EXC_PC]        = fault_pc_in;
  assign exc_ev[EXC_SP]        = fault_sp_in;
  assign exc_ev[EXC_PSW]       = fault_psw_in;
  assign exc_ev[EXC_DES]       = fault_des_in;
  assign exc_ev[EXC_MODARITH]  = fault_modarith_in;
  assign exc_ev[EXC_STK_USER]  = stk_hit[MODE_USER];
  assign exc_ev[EXC_STK_SYS]   = stk_hit[MODE_SYS];
  assign exc_ev[EXC_STK_SUPER] = stk_hit[MODE_SUPER];
  assign any_exc = (|exc_ev) && !any_rst;

  byte_ecc_correct u_ecc (
    .data_in      (ee_data_in),
    .check_in     (ee_check_in),
    .data_out     (ee_data_out),
    .corrected_out(ee_corrected_out)
  );

  // ==========================================================
  // Register decode
  logic wr_clear;
  logic wr_enable;
  logic wr_light;
  logic wr_lim_sel;
  logic wr_lim_lo;
  logic wr_lim_hi;

  assign wr_clear   = wr_in && (addr_in == ADDR_EXC_CLEAR);
  assign wr_enable  = wr_in && (addr_in == ADDR_EXC_ENABLE);
  assign wr_light   = wr_in && (addr_in == ADDR_LIGHT_SEL) &&
                      (wdata_in[1:0] != 2'h3);
  assign wr_lim_sel = wr_in && (addr_in == ADDR_SENSOR_CTRL);
  assign wr_lim_lo  = wr_in && (addr_in == ADDR_SP_LIMIT_LO);
  assign wr_lim_hi  = wr_in && (addr_in == ADDR_SP_LIMIT_HI);

  // Set wins over a clear in the same cycle
  assign exc_stat_nxt = (exc_stat_r & ~(wr_clear ? wdata_in[EXC_BITS-1:0] : '0))
                        | (any_exc ? exc_ev : '0);

  // Cause is latched on the first clock after release, from the pending capture, else power-on or other
  assign cause_nxt = (pend_cause_r != '0) ? pend_cause_r :
                     poweron_in ? (CAUSE_BITS'(1) << CAUSE_POWERON) :
                                  (CAUSE_BITS'(1) << CAUSE_OTHER);

  // ==========================================================
  // Pending cause: power-on starts it clean, since its flops wake up unknown;
  // other resets keep it until the first edge after release copies it out
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in && poweron_in) begin
      pend_cause_r <= '0;
    end else if (any_rst) begin
      pend_cause_r <= rst_ev;
    end else if (rst_n_in && !cause_caught_r) begin
      pend_cause_r <= '0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      cause_caught_r <= 1'b0;
      cause_r        <= '0;
    end else if (!cause_caught_r) begin
      cause_caught_r <= 1'b1;
      cause_r        <= cause_nxt;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      rst_cnt_r <= '0;
    end else if (any_rst) begin
      rst_cnt_r <= RESET_PULSE_CYC;
    end else if (rst_cnt_r != '0) begin
      rst_cnt_r <= rst_cnt_r - 4'h1;
    end
  end

  assign reset_req_out = any_rst || (rst_cnt_r != '0);

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      exc_stat_r  <= '0;
      exc_en_r    <= '0;
      light_sel_r <= LIGHT_SEL_RESET;
      exc_r       <= 1'b0;
    end else begin
      exc_stat_r <= exc_stat_nxt;
      exc_r      <= any_exc;
      if (wr_enable) begin
        exc_en_r <= wdata_in[EXC_BITS-1:0];
      end
      if (wr_light) begin
        light_sel_r <= wdata_in[1:0];
      end
    end
  end

  assign exception_out = exc_r;
  assign irq_out       = |(exc_stat_r & exc_en_r);

  // Voltage result is only posted; nothing else reads it
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      hv_fail_r <= 1'b0;
      hv_done_r <= 1'b0;
    end else if (ee_write_in) begin
      hv_done_r <= 1'b1;
      hv_fail_r <= hv_fail_r || !hv_ok_in;
    end else if (wr_in && (addr_in == ADDR_HV_STATUS)) begin
      hv_fail_r <= 1'b0;
      hv_done_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      lim_sel_r <= 2'h0;
      for (int i = 0; i < 3; i++) begin
        lim_lo_r[i] <= SP_LIMIT_RESET[SP_W-1:0];
        lim_hi_r[i] <= ~SP_LIMIT_RESET[SP_W-1:0];
      end
    end else begin
      if (wr_lim_sel && wdata_in[1:0] != 2'h3) begin
        lim_sel_r <= wdata_in[1:0];
      end
      if (wr_lim_lo) begin
        lim_lo_r[lim_sel_r] <= wdata_in[SP_W-1:0];
      end
      if (wr_lim_hi) begin
        lim_hi_r[lim_sel_r] <= wdata_in[SP_W-1:0];
      end
    end
  end

  // ==========================================================
  // Read path
  logic [15:0] rd_mux;

  always_comb begin
    rd_mux = 16'h0000;
    unique case (addr_in)
      ADDR_RESET_CAUSE: rd_mux = 16'(cause_r);
      ADDR_EXC_STATUS:  rd_mux = 16'(exc_stat_r);
      ADDR_EXC_ENABLE:  rd_mux = 16'(exc_en_r);
      ADDR_LIGHT_SEL:   rd_mux = 16'(light_sel_r);
      ADDR_HV_STATUS:   rd_mux = {14'h0000, hv_done_r, hv_fail_r};
      ADDR_SP_LIMIT_LO: rd_mux = 16'(lim_lo_r[lim_sel_r]);
      ADDR_SP_LIMIT_HI: rd_mux = 16'(lim_hi_r[lim_sel_r]);
      ADDR_SENSOR_CTRL: rd_mux = {13'h0000, sensors_en_out, lim_sel_r};
      default:          rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rd_in ? rd_mux : 16'h0000;
    end
  end

  assign rdata_out = rdata_r;
endmodule : fault_response_monitor

// file: design/stack_limit_check.sv
/*
 One stack pointer limit checker for a single processor mode.
 Assumes the pointer and its bounds are synchronous to mclk_in.
*/
module stack_limit_check
  import fault_pkg::*;
#(
  parameter int SP_W = 16
) (
  input  wire logic            mclk_in,     // System clock
  input  wire logic            rst_n_in,    // Synchronous reset, active low
  input  wire logic            active_in,   // This mode's pointer is in use
  input  wire logic [SP_W-1:0] sp_in,       // Stack pointer of this mode
  input  wire logic [SP_W-1:0] lo_in,       // Lower bound
  input  wire logic [SP_W-1:0] hi_in,       // Upper bound
  output logic                 hit_out      // One-cycle pulse on reaching a bound
);
  if (SP_W < 2) begin : g_bad_sp_w
    $error("SP_W too small");
  end

  logic at_limit;
  logic at_limit_r;

  // Reaching either bound counts, not only passing it
  assign at_limit = active_in && ((sp_in <= lo_in) || (sp_in >= hi_in));

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      at_limit_r <= 1'b0;
    end else begin
      at_limit_r <= at_limit;
    end
  end

  // Edge only, so a pointer parked on a bound does not flood exceptions
  assign hit_out = at_limit && !at_limit_r;
endmodule : stack_limit_check

// file: verif/fault_monitor_properties.sv
/*
 Concurrent checks on the ports of the fault response monitor.
 Assumes one clock domain and the synchronous active-low reset of the monitor.
*/
module fault_monitor_properties (
  input wire logic        mclk_in,           // System clock
  input wire logic        rst_n_in,          // Synchronous reset, active low
  input wire logic        test_mode_in,      // Factory test mode
  input wire logic        volt_alarm_in,     // Supply alarm
  input wire logic        freq_alarm_in,     // Frequency alarm
  input wire logic        temp_alarm_in,     // Temperature alarm
  input wire logic        light_alarm_in,    // Surface light alarm
  input wire logic        fault_pc_in,       // Program counter fault
  input wire logic        fault_sp_in,       // Stack pointer fault
  input wire logic        fault_psw_in,      // Status register fault
  input wire logic        fault_des_in,      // Cipher fault
  input wire logic        fault_modarith_in, // Modular arithmetic fault
  input wire logic        rom_rd_in,         // ROM read strobe
  input wire logic [7:0]  rom_data_in,       // ROM byte
  input wire logic        rom_parity_in,     // ROM parity bit
  input wire logic        ee_write_in,       // EEPROM write active
  input wire logic        hv_ok_in,          // Write voltage good
  input wire logic [15:0] rdata_out,         // Read data
  input wire logic        sensors_en_out,    // Sensor enable
  input wire logic        reset_req_out,     // Chip reset request
  input wire logic        exception_out,     // Exception pulse
  input wire logic        irq_out            // Level interrupt
);
  // ==========================================================
  // Event decode
  logic sensor_ev;
  logic rom_err;
  logic rst_ev;
  logic fault_any;
  assign sensor_ev = !test_mode_in &&
                     (volt_alarm_in || freq_alarm_in || temp_alarm_in || light_alarm_in);
  assign rom_err   = rom_rd_in && !(^{rom_data_in, rom_parity_in});
  assign rst_ev    = sensor_ev || rom_err;
  assign fault_any = fault_pc_in || fault_sp_in || fault_psw_in || fault_des_in ||
                     fault_modarith_in;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  // ==========================================================
  // Properties
  sequence s_quiet;
    !rst_ev && !reset_req_out;
  endsequence
  sequence s_hv_fail;
    !rst_ev && ee_write_in && !hv_ok_in;
  endsequence

  a_sensor_reset_held: assert property (sensor_ev |-> reset_req_out [*5])
    else $error("sensor alarm did not hold reset request for five cycles");
  a_rom_parity_reset: assert property (rom_err |-> reset_req_out)
    else $error("ROM parity error did not force reset");
  a_fault_exception: assert property (fault_any && !rst_ev |=> exception_out)
    else $error("fault detector did not raise exception");
  a_reset_wins: assert property (fault_any && rst_ev |=> !exception_out)
    else $error("exception raised beside reset event");
  a_test_mode_off: assert property (test_mode_in |-> !sensors_en_out)
    else $error("sensors enabled in test mode");
  a_sensors_always_on: assert property (!test_mode_in |-> sensors_en_out)
    else $error("sensors disabled outside test mode");
  a_hv_no_event: assert property (s_quiet ##1 s_hv_fail |-> !reset_req_out)
    else $error("write voltage failure forced reset");
  a_reset_clears: assert property ($rose(rst_n_in) |->
                                   !exception_out && !irq_out && rdata_out == 16'h0000)
    else $error("outputs not at reset values after reset");
endmodule : fault_monitor_properties

bind fault_response_monitor fault_monitor_properties u_props (.*);

// file: verif/sensor_array_model.sv
/*
 Behavioural sensors and fault detectors facing the monitor.
 Assumes the bench requests one-cycle detections through kick_in.
*/
module sensor_array_model (
  input  wire logic        mclk_in,   // System clock
  input  wire logic [10:0] kick_in,   // Detection request per source
  output logic      [10:0] alarm_out  // 0-3 sensors, 4-5 EEPROM light, 6-10 faults
);
  timeunit 1ns;
  timeprecision 100ps;
  // Detector outputs are registered, as real detectors resynchronise to the clock
  always_ff @(posedge mclk_in) begin
    alarm_out <= kick_in;
  end
endmodule : sensor_array_model

// file: verif/testbench.sv
/*
 Self-checking bench for the fault response monitor.
 Assumes the bench plays the chip reset generator and software's register port.
*/
module testbench
  import fault_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk_in, rst_n_in, test_mode_in, poweron_in, user_mode_in, wr_in, rd_in;
  logic        rom_rd_in, rom_parity_in, ee_write_in, hv_ok_in;
  logic [7:0]  processor_status_high_in, rom_data_in, ee_data_in, ee_data_out;
  logic [15:0] sp_user_in, sp_sys_in, sp_super_in, wdata_in, rdata_out, d;
  logic [3:0]  ee_check_in, addr_in;
  logic [10:0] kick, alarm;
  logic        ee_corrected_out, sensors_en_out, reset_req_out, exception_out, irq_out;
  int          n_mismatch, total_checks, ne, nr;
  logic [15:0] exp_tab [10] = '{16'h0020, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                                16'h0000, 16'h0000, 16'hffff, 16'h0004, 16'h0000};

  sensor_array_model u_sensors (.mclk_in(mclk_in), .kick_in(kick), .alarm_out(alarm));
  fault_response_monitor dut (.volt_alarm_in(alarm[0]), .freq_alarm_in(alarm[1]),
    .temp_alarm_in(alarm[2]), .light_alarm_in(alarm[3]), .ee_light_a_in(alarm[4]),
    .ee_light_b_in(alarm[5]), .fault_pc_in(alarm[6]), .fault_sp_in(alarm[7]),
    .fault_psw_in(alarm[8]), .fault_des_in(alarm[9]), .fault_modarith_in(alarm[10]), .*);

  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge mclk_in);
    addr_in <= a; wdata_in <= v; wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge mclk_in);
    addr_in <= a; rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask : reg_rd
  // Counts exception pulses and reset request cycles caused by one detection;
  // the bad ROM read lands in the cycle in which the registered detectors report
  task automatic fire(input logic [10:0] m, input logic bad_rom);
    ne = 0;
    nr = 0;
    @(posedge mclk_in);
    kick <= m; rom_data_in <= 8'h01; rom_parity_in <= 1'b1;
    for (int c = 0; c < 11; c++) begin
      @(posedge mclk_in);
      kick <= 11'h000; rom_rd_in <= bad_rom && (c == 0);
      #1 ne += int'(exception_out !== 1'b0);
      nr += int'(reset_req_out !== 1'b0);
    end
  endtask : fire
  task automatic do_reset();
    @(posedge mclk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
  endtask : do_reset
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test

  // ==========================================================
  // Scenarios
  task automatic s_reset_values();
    for (int a = 0; a < 10; a++) begin
      if (a != 2) begin
        reg_rd(4'(a), d);
        chk(d, exp_tab[a]);
      end
    end
    reg_wr(4'h9, 16'hffff);
    reg_rd(ADDR_EXC_ENABLE, d);
    chk(d, 16'h0000);
  endtask : s_reset_values
  task automatic s_faults();
    reg_wr(ADDR_EXC_ENABLE, 16'h01ff);
    for (int i = 6; i < 11; i++) begin
      fire(11'h001 << i, 1'b0);
      chk(16'(ne), 16'h0001);
      chk(16'(irq_out), 16'h0001);
      reg_rd(ADDR_EXC_STATUS, d);
      chk(d, 16'h0001 << (i - 5));
      reg_wr(ADDR_EXC_CLEAR, 16'h01ff);
      #1 chk(16'(irq_out), 16'h0000);
    end
    reg_wr(ADDR_EXC_ENABLE, 16'h0000);
    fire(11'h040, 1'b0);
    chk(16'(irq_out), 16'h0000);
    reg_rd(ADDR_EXC_STATUS, d);
    chk(d, 16'h0002);
  endtask : s_faults
  task automatic s_sensors();
    for (int i = 0; i < 5; i++) begin
      reg_wr(ADDR_SENSOR_CTRL, 16'h0000);
      chk(16'(sensors_en_out), 16'h0001);
      // A fault beside each sensor alarm must lose to the reset
      fire((i < 4) ? ((11'h001 << i) | 11'h040) : 11'h040, i == 4);
      chk(16'(nr), 16'h0005);
      chk(16'(ne), 16'h0000);
      do_reset();
      reg_rd(ADDR_RESET_CAUSE, d);
      chk(d, (i < 4) ? (16'h0001 << i) : 16'h0010);
    end
    do_reset();
    reg_rd(ADDR_RESET_CAUSE, d);
    chk(d, 16'h0040);
  endtask : s_sensors
  task automatic s_test_mode();
    @(posedge mclk_in);
    test_mode_in <= 1'b1;
    fire(11'h001, 1'b0);
    chk(16'(nr), 16'h0000);
    chk(16'(sensors_en_out), 16'h0000);
    @(posedge mclk_in);
    test_mode_in <= 1'b0;
  endtask : s_test_mode
  task automatic s_ee_light();
    logic [1:0]  sel [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
    logic [10:0] src [5] = '{11'h010, 11'h010, 11'h020, 11'h020, 11'h010};
    logic [15:0] hit [5] = '{16'h0000, 16'h0001, 16'h0000, 16'h0001, 16'h0000};
    for (int i = 0; i < 5; i++) begin
      reg_wr(ADDR_LIGHT_SEL, {14'h0000, sel[i]});
      fire(src[i], 1'b0);
      chk(16'(ne), hit[i]);
    end
    reg_wr(ADDR_LIGHT_SEL, 16'h0003);
    reg_rd(ADDR_LIGHT_SEL, d);
    chk(d, 16'h0002);
  endtask : s_ee_light
  task automatic s_stack();
    reg_wr(ADDR_EXC_CLEAR, 16'h01ff);
    reg_wr(ADDR_SENSOR_CTRL, 16'h0000);
    reg_wr(ADDR_SP_LIMIT_LO, 16'h0100);
    reg_wr(ADDR_SP_LIMIT_HI, 16'h0200);
    sp_user_in <= 16'h0200;
    repeat (3) @(posedge mclk_in);
    reg_rd(ADDR_EXC_STATUS, d);
    chk(d, 16'h0040);
    reg_wr(ADDR_EXC_CLEAR, 16'h01ff);
    processor_status_high_in <= 8'h80;
    sp_user_in <= 16'h0100;
    @(posedge mclk_in);
    sp_super_in <= 16'hffff;
    repeat (3) @(posedge mclk_in);
    reg_rd(ADDR_EXC_STATUS, d);
    chk(d, 16'h0100);
    reg_wr(ADDR_EXC_CLEAR, 16'h01ff);
    processor_status_high_in <= 8'h00;
    user_mode_in <= 1'b0;
    @(posedge mclk_in);
    sp_sys_in <= 16'h0000;
    repeat (3) @(posedge mclk_in);
    reg_rd(ADDR_EXC_STATUS, d);
    chk(d, 16'h0080);
  endtask : s_stack
  task automatic s_hv();
    reg_wr(ADDR_EXC_CLEAR, 16'h01ff);
    ee_write_in <= 1'b1;
    hv_ok_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    ee_write_in <= 1'b0;
    hv_ok_in <= 1'b1;
    reg_rd(ADDR_HV_STATUS, d);
    chk(d, 16'h0003);
    reg_rd(ADDR_EXC_STATUS, d);
    chk(d, 16'h0000);
    reg_wr(ADDR_HV_STATUS, 16'h0000);
    reg_rd(ADDR_HV_STATUS, d);
    chk(d, 16'h0000);
  endtask : s_hv
  // All-zero byte and check bits form a codeword, so any single data-bit flip must come back
  task automatic s_ecc();
    for (int i = 0; i < 9; i++) begin
      @(posedge mclk_in);
      ee_data_in <= (i < 8) ? (8'h01 << i) : 8'h00;
      ee_check_in <= 4'h0;
      #1 chk({8'h00, ee_data_out}, 16'h0000);
      chk(16'(ee_corrected_out), (i < 8) ? 16'h0001 : 16'h0000);
    end
  endtask : s_ecc

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    {rst_n_in, test_mode_in, wr_in, rd_in, rom_rd_in, rom_parity_in, ee_write_in} = '0;
    {poweron_in, user_mode_in, hv_ok_in} = 3'h7;
    {processor_status_high_in, rom_data_in, ee_data_in, ee_check_in, addr_in} = '0;
    {sp_user_in, sp_sys_in, sp_super_in} = {16'h0150, 16'h8000, 16'h8000};
    {wdata_in, kick} = '0;
    repeat (5) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    poweron_in <= 1'b0;
    s_reset_values();
    s_faults();
    s_sensors();
    s_test_mode();
    s_ee_light();
    s_stack();
    s_hv();
    s_ecc();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge mclk_in);
    n_mismatch++;
    end_of_test();
  end
endmodule : testbench
